// >>> logic/dbf_host_seq.sv
// Host side bus sequencer for a dual bank asynchronous byte wide flash.
//
// Summary of operation
// - Reset: one select, OE, WE low over 5us.
// - Never drive both bank selects low together.
// - Selects and OE high once after power-up.
// - Triple low pattern only for chip reset.
// - Confirm success by reading status after write.
// - Ignore status bits 2 to 0 when polling.
`timescale 1ns/10ps
module dbf_host_seq #(
    parameter int ADDR_W = 18,
    parameter logic [31:0] POLL_TIMEOUT_CYC = 32'hB2D05E00
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // User command port.
    input wire logic i_cmd_valid,
    input wire logic [1:0] i_cmd_op,
    input wire logic i_cmd_bank,
    input wire logic i_cmd_sel_ctl,
    input wire logic [ADDR_W-1:0] i_cmd_addr,
    input wire logic [7:0] i_cmd_data,
    output logic o_cmd_ready,
    // User answer port.
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic o_ready_seen,
    output logic o_timeout,
    // Flash pins.
    output logic o_bank0_select_n,
    output logic o_bank1_select_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [7:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [7:0] i_dq_in
);
    localparam int CNT_W = 10;

    initial begin
        if (ADDR_W < 1 || dbf_pkg::CYC_RESET_LOW >= (1 << CNT_W)) begin
            $error("dbf_host_seq: unsupported parameter values");
        end
    end

    dbf_pkg::dbf_state_t state_reg;
    dbf_pkg::dbf_state_t state_next;
    logic [1:0] op_reg;
    logic bank_reg;
    logic sel_ctl_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic ready_reg;
    logic timeout_reg;
    logic done_reg;
    logic [31:0] poll_cnt_reg;
    logic sel0_n_reg;
    logic sel1_n_reg;
    logic oe_n_reg;
    logic we_n_reg;
    logic dq_oe_reg;

    wire expired;
    wire [CNT_W-1:0] target;
    wire is_reset = (op_reg == dbf_pkg::OP_RESET);
    wire is_write = (op_reg == dbf_pkg::OP_WRITE);
    wire is_poll = (op_reg == dbf_pkg::OP_POLL);
    wire is_read = (op_reg == dbf_pkg::OP_READ) || is_poll;
    wire accept = (state_reg == dbf_pkg::ST_IDLE) && i_cmd_valid;
    wire capture = (state_reg == dbf_pkg::ST_ACTIVE) && is_read && expired;
    // Only the status bit that the write machine drives decides readiness.
    wire [7:0] masked_status = i_dq_in & dbf_pkg::STAT_MASK;
    wire wms_ready = (masked_status[dbf_pkg::STAT_WMS_BIT] == dbf_pkg::STAT_READY_VAL);
    wire poll_over = (poll_cnt_reg >= POLL_TIMEOUT_CYC);
    wire poll_again = is_poll && !ready_reg && !timeout_reg;
    wire phase_change = (state_next != state_reg);

    // Length of each phase for the current operation.
    assign target =
        (state_reg == dbf_pkg::ST_INIT) ? CNT_W'(dbf_pkg::CYC_INIT) :
        (state_reg == dbf_pkg::ST_SETUP) ?
            (is_reset ? CNT_W'(dbf_pkg::CYC_RST_SETUP) : CNT_W'(dbf_pkg::CYC_ONE)) :
        (state_reg == dbf_pkg::ST_ACTIVE) ?
            (is_reset ? CNT_W'(dbf_pkg::CYC_RESET_LOW) :
             is_write ? CNT_W'(dbf_pkg::CYC_WR_PULSE) : CNT_W'(dbf_pkg::CYC_RD_ACCESS)) :
        (state_reg == dbf_pkg::ST_HOLD) ?
            (is_reset ? CNT_W'(dbf_pkg::CYC_RST_HOLD) : CNT_W'(dbf_pkg::CYC_WR_HOLD)) :
        (is_reset ? CNT_W'(dbf_pkg::CYC_RST_VALID) :
         is_write ? CNT_W'(dbf_pkg::CYC_WR_RECOVER) : CNT_W'(dbf_pkg::CYC_RD_RECOVER));

    dbf_phase_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_clear(phase_change),
        .i_target(target),
        .o_expired(expired)
    );

    // Phase sequencing; reads skip the hold phase.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dbf_pkg::ST_INIT: begin
                if (expired) begin
                    state_next = dbf_pkg::ST_IDLE;
                end
            end
            dbf_pkg::ST_IDLE: begin
                if (i_cmd_valid) begin
                    state_next = dbf_pkg::ST_SETUP;
                end
            end
            dbf_pkg::ST_SETUP: begin
                if (expired) begin
                    state_next = dbf_pkg::ST_ACTIVE;
                end
            end
            dbf_pkg::ST_ACTIVE: begin
                if (expired) begin
                    state_next = is_read ? dbf_pkg::ST_RECOVER : dbf_pkg::ST_HOLD;
                end
            end
            dbf_pkg::ST_HOLD: begin
                if (expired) begin
                    state_next = dbf_pkg::ST_RECOVER;
                end
            end
            dbf_pkg::ST_RECOVER: begin
                if (expired) begin
                    state_next = poll_again ? dbf_pkg::ST_SETUP : dbf_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = dbf_pkg::ST_INIT;
            end
        endcase
    end

    // Pin levels wanted in the next cycle, decoded from the phase.
    wire nxt_setup = (state_next == dbf_pkg::ST_SETUP);
    wire nxt_active = (state_next == dbf_pkg::ST_ACTIVE);
    wire nxt_hold = (state_next == dbf_pkg::ST_HOLD);
    wire nxt_busy = nxt_setup || nxt_active || nxt_hold;
    wire nxt_we_op = accept ? (i_cmd_op == dbf_pkg::OP_WRITE) : is_write;
    wire nxt_rst_op = accept ? (i_cmd_op == dbf_pkg::OP_RESET) : is_reset;
    wire nxt_sc_op = accept ? i_cmd_sel_ctl : sel_ctl_reg;
    wire nxt_bank = accept ? i_cmd_bank : bank_reg;
    // In select mode the select pulses only in the active phase, WE low around it.
    wire sel_low = nxt_we_op && nxt_sc_op ? nxt_active : nxt_busy;
    // WE is low in the active phase of a strobe write or a reset, and from setup through hold of a select write.
    wire we_low = (nxt_we_op && nxt_sc_op) ? nxt_busy :
                  ((nxt_we_op || nxt_rst_op) && nxt_active);
    // OE is low for reads and across a reset, never during a command write.
    wire oe_low = !nxt_we_op && (nxt_rst_op ? nxt_busy : nxt_active);
    wire dq_drive = nxt_we_op && nxt_busy;

    // Pin registers; at most one select ever goes low.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sel0_n_reg <= 1'b1;
            sel1_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
        end else begin
            sel0_n_reg <= !(sel_low && !nxt_bank);
            sel1_n_reg <= !(sel_low && nxt_bank);
            oe_n_reg <= !oe_low;
            we_n_reg <= !we_low;
            dq_oe_reg <= dq_drive;
        end
    end

    // State and command capture.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= dbf_pkg::ST_INIT;
            op_reg <= dbf_pkg::OP_RESET;
            bank_reg <= 1'b0;
            sel_ctl_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (accept) begin
                op_reg <= i_cmd_op;
                bank_reg <= i_cmd_bank;
                sel_ctl_reg <= i_cmd_sel_ctl;
                addr_reg <= i_cmd_addr;
                wdata_reg <= i_cmd_data;
            end
        end
    end

    // Read data, poll result and completion pulse.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_reg <= 8'h00;
            ready_reg <= 1'b0;
            timeout_reg <= 1'b0;
            done_reg <= 1'b0;
            poll_cnt_reg <= 32'h00000000;
        end else begin
            done_reg <= (state_reg == dbf_pkg::ST_RECOVER) && expired && !poll_again;
            if (accept) begin
                ready_reg <= 1'b0;
                timeout_reg <= 1'b0;
                poll_cnt_reg <= 32'h00000000;
            end else if (is_poll && state_reg != dbf_pkg::ST_IDLE && !poll_over) begin
                poll_cnt_reg <= poll_cnt_reg + 32'h00000001;
            end
            if (capture) begin
                rdata_reg <= is_poll ? masked_status : i_dq_in;
                ready_reg <= is_poll && wms_ready;
                timeout_reg <= is_poll && !wms_ready && poll_over;
            end
        end
    end

    // Outputs.
    assign o_cmd_ready = (state_reg == dbf_pkg::ST_IDLE);
    assign o_done = done_reg;
    assign o_rdata = rdata_reg;
    assign o_ready_seen = ready_reg;
    assign o_timeout = timeout_reg;
    assign o_bank0_select_n = sel0_n_reg;
    assign o_bank1_select_n = sel1_n_reg;
    assign o_oe_n = oe_n_reg;
    assign o_we_n = we_n_reg;
    assign o_addr = addr_reg;
    assign o_dq_out = wdata_reg;
    assign o_dq_oe = dq_oe_reg;
endmodule : dbf_host_seq

// >>> logic/dbf_phase_timer.sv
// Cycle counter that measures the time spent in one sequencer phase.
`timescale 1ns/10ps
module dbf_phase_timer #(
    parameter int CNT_W = 10
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Control.
    input wire logic i_clear,
    input wire logic [CNT_W-1:0] i_target,
    // Status.
    output logic o_expired
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic saturated;

    initial begin
        if (CNT_W < 2) begin
            $error("dbf_phase_timer: CNT_W too small");
        end
    end

    // The phase ends in the cycle whose count reaches the target less one.
    assign saturated = (count_reg == {CNT_W{1'b1}});
    assign o_expired = (count_reg >= (i_target - {{(CNT_W-1){1'b0}}, 1'b1}));
    assign count_next = i_clear ? '0 : (saturated ? count_reg : count_reg + 1'b1);

    // Counter register.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule : dbf_phase_timer

// >>> logic/dbf_pkg.sv
// Shared constants for the dual bank flash bus sequencer.
package dbf_pkg;
    // Clock period of i_mclk in nanoseconds.
    localparam int CLK_PERIOD_NS = 10;

    // Pin timing figures in nanoseconds.
    localparam int T_RESET_LOW_NS = 5000;   // Least time of the triple low reset pattern.
    localparam int T_RST_SETUP_NS = 100;    // Select and output enable setup to strobe low.
    localparam int T_RST_HOLD_NS = 100;     // Select and output enable hold after strobe high.
    localparam int T_RST_VALID_NS = 500;    // Strobe high to valid data after reset.
    localparam int T_WR_PULSE_NS = 110;     // Strobe or select pulse width, also address setup.
    localparam int T_WR_HOLD_NS = 10;       // Address, data and select hold after rising edge.
    localparam int T_WR_RECOVER_NS = 120;   // Write recovery before the next read.
    localparam int T_RD_ACCESS_NS = 150;    // Select to output delay.
    localparam int T_RD_RECOVER_NS = 60;    // Output float after release, with margin.
    localparam int T_INIT_NS = 100;         // All selects and output enable high after power-up.

    // Cycle counts, least times rounded up; reset low adds one cycle, read access two.
    localparam int CYC_RESET_LOW = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int CYC_RST_SETUP = (T_RST_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_RST_HOLD = (T_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_RST_VALID = (T_RST_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_WR_PULSE = (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_WR_HOLD = (T_WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_WR_RECOVER = (T_WR_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_RD_ACCESS = (T_RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
    localparam int CYC_RD_RECOVER = (T_RD_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_INIT = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_ONE = 1;

    // Operation codes on the user command port.
    localparam logic [1:0] OP_RESET = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_POLL = 2'h3;

    // Status register layout.
    localparam int STAT_WMS_BIT = 7;
    localparam logic STAT_READY_VAL = 1'b1;
    localparam logic [7:0] STAT_MASK = 8'hF8;

    // Sequencer states, one-hot.
    typedef enum logic [5:0] {
        ST_INIT = 6'h01,
        ST_IDLE = 6'h02,
        ST_SETUP = 6'h04,
        ST_ACTIVE = 6'h08,
        ST_HOLD = 6'h10,
        ST_RECOVER = 6'h20
    } dbf_state_t;
endpackage : dbf_pkg

// >>> tb/dbf_flash_model.sv
// Behavioural model of the dual bank flash as seen at its pins.
`timescale 1ns/10ps
module dbf_flash_model #(
    parameter int ADDR_W = 18,
    parameter int BUSY_NS = 8000
) (
    // Pins from the host.
    input wire logic i_bank0_select_n,
    input wire logic i_bank1_select_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_dq,
    // Keeps writes captured while high busy until a chip reset.
    input wire logic i_stall,
    // Data towards the host.
    output logic [7:0] o_dq
);
    realtime rdy_at [2] = '{0.0, 0.0};
    realtime tri_t;
    int rst_cnt = 0;
    logic [ADDR_W-1:0] lat_addr;
    logic [7:0] lat_data;
    logic [7:0] idle_q = 8'h5A;
    wire sel = !i_bank0_select_n || !i_bank1_select_n;
    wire bk = !i_bank1_select_n;
    wire tri_low = sel && !i_oe_n && !i_we_n;
    // Status of one bank; low bits are reserved and left nonzero.
    function automatic logic [7:0] stat(input logic b);
        return ($realtime >= rdy_at[b]) ? 8'h85 : 8'h05;
    endfunction : stat
    // Captures a command cycle and starts the write machine.
    task automatic latch(input logic b);
        lat_addr = i_addr;
        lat_data = i_dq;
        rdy_at[b] = i_stall ? 1.0e18 : $realtime + BUSY_NS;
    endtask : latch
    // Strobe controlled capture.
    always @(posedge i_we_n) if (sel && i_oe_n) latch(bk);
    // Select controlled capture.
    always @(posedge i_bank0_select_n) if (!i_we_n) latch(1'b0);
    always @(posedge i_bank1_select_n) if (!i_we_n) latch(1'b1);
    // Chip reset once the triple low pattern lasts past 5 us.
    always @(posedge tri_low) tri_t = $realtime;
    always @(negedge tri_low) begin
        if ($realtime - tri_t > 5000.0) begin
            rst_cnt++;
            rdy_at = '{0.0, 0.0};
        end
    end
    // Reads are served in any bank state; released bus shows the inverse.
    always @* o_dq = (sel && !i_oe_n) ? stat(bk) : idle_q;
    always @(posedge i_oe_n) idle_q <= ~stat(bk);
endmodule : dbf_flash_model

// >>> tb/dbf_host_seq_checker.sv
// Concurrent checks on the flash pins driven by the host sequencer.
`timescale 1ns/10ps
module dbf_host_seq_checker #(
    parameter int ADDR_W = 18
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Observed pins.
    input wire logic o_bank0_select_n,
    input wire logic o_bank1_select_n,
    input wire logic o_oe_n,
    input wire logic o_we_n,
    input wire logic [ADDR_W-1:0] o_addr,
    input wire logic [7:0] o_dq_out,
    input wire logic o_dq_oe,
    input wire logic o_timeout
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    // Decoded pin patterns.
    wire anysel_n = o_bank0_select_n & o_bank1_select_n;
    wire trip = !anysel_n && !o_oe_n && !o_we_n;
    logic [9:0] tri_cnt;
    // Counts cycles of the triple low reset pattern.
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tri_cnt <= '0;
        end else begin
            tri_cnt <= trip ? tri_cnt + 10'h001 : 10'h000;
        end
    end
    property p_dual_sel; !(!o_bank0_select_n && !o_bank1_select_n); endproperty
    a_dual_sel: assert property (p_dual_sel) else $error("both selects low");
    property p_init_high; $rose(i_nrst) |-> (!anysel_n ? 1'b0 : o_oe_n)[*8]; endproperty
    a_init_high: assert property (p_init_high) else $error("pins not high after reset");
    // At the falling edge the sampled count already includes the last low cycle.
    property p_rst_len; $fell(trip) |-> tri_cnt > 10'h1F4; endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pattern too short");
    property p_we_width; $fell(o_we_n) && o_oe_n |-> !o_we_n[*8] ##1 !o_we_n[*3]; endproperty
    a_we_width: assert property (p_we_width) else $error("strobe pulse too short");
    // Of the writes, only a strobe write has the select low across the strobe; select writes are excluded.
    property p_we_hold;
        $rose(o_we_n) && o_oe_n && !$past(anysel_n) |->
            !anysel_n && o_dq_oe && $stable(o_addr);
    endproperty
    a_we_hold: assert property (p_we_hold) else $error("no hold after strobe rise");
    property p_sel_width; $fell(anysel_n) && !o_we_n |-> !anysel_n[*8] ##1 !anysel_n[*3];
    endproperty
    a_sel_width: assert property (p_sel_width) else $error("select pulse too short");
    property p_sel_hold;
        $rose(anysel_n) && !o_we_n |-> $stable(o_addr) && $stable(o_dq_out) && o_dq_oe;
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("no hold after select rise");
    property p_wr_recover; $rose(o_we_n) && o_oe_n |-> o_oe_n[*8] ##1 o_oe_n[*4]; endproperty
    a_wr_recover: assert property (p_wr_recover) else $error("read too soon after write");
    property p_rd_access; $fell(o_oe_n) && o_we_n |-> !o_oe_n[*8] ##1 !o_oe_n[*7]; endproperty
    a_rd_access: assert property (p_rd_access) else $error("read strobe too short");
    // Main scenarios reached.
    c_reset: cover property ($fell(trip));
    c_sel_write: cover property ($rose(anysel_n) && !o_we_n);
    c_timeout: cover property ($rose(o_timeout));
endmodule : dbf_host_seq_checker

// >>> tb/tb_dual_bank_flash_bus_control.sv
// Self-checking bench for the dual bank flash host sequencer.
`timescale 1ns/10ps
module tb_dual_bank_flash_bus_control;
    localparam int ADDR_W = 18;
    logic i_mclk, i_nrst, i_cmd_valid, i_cmd_bank, i_cmd_sel_ctl, stall, o_cmd_ready, o_done;
    logic o_ready_seen, o_timeout, o_bank0_select_n, o_bank1_select_n, o_oe_n, o_we_n, o_dq_oe;
    logic [1:0] i_cmd_op;
    logic [ADDR_W-1:0] i_cmd_addr, o_addr;
    logic [7:0] i_cmd_data, o_rdata, o_dq_out, i_dq_in;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    realtime t0;
    dbf_host_seq #(.ADDR_W(ADDR_W), .POLL_TIMEOUT_CYC(32'h0000_1000)) uut (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
        .i_cmd_bank(i_cmd_bank), .i_cmd_sel_ctl(i_cmd_sel_ctl), .i_cmd_addr(i_cmd_addr),
        .i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
        .o_rdata(o_rdata), .o_ready_seen(o_ready_seen), .o_timeout(o_timeout),
        .o_bank0_select_n(o_bank0_select_n), .o_bank1_select_n(o_bank1_select_n),
        .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr), .o_dq_out(o_dq_out),
        .o_dq_oe(o_dq_oe), .i_dq_in(i_dq_in));
    dbf_flash_model #(.ADDR_W(ADDR_W)) u_flash (
        .i_bank0_select_n(o_bank0_select_n), .i_bank1_select_n(o_bank1_select_n),
        .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_addr), .i_dq(o_dq_out),
        .i_stall(stall), .o_dq(i_dq_in));
    // Clock generator.
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Compares one value and counts the result.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Issues one command and waits for its completion pulse.
    task automatic cmd(input logic [1:0] op, input logic bk, input logic sc,
                       input logic [ADDR_W-1:0] a, input logic [7:0] d);
        i_cmd_valid <= 1'b1;
        i_cmd_op <= op;
        i_cmd_bank <= bk;
        i_cmd_sel_ctl <= sc;
        i_cmd_addr <= a;
        i_cmd_data <= d;
        do @(posedge i_mclk); while (o_cmd_ready !== 1'b1);
        i_cmd_valid <= 1'b0;
        do @(posedge i_mclk); while (o_done !== 1'b1);
    endtask : cmd
    // Chip reset pattern on bank 1.
    task automatic t_reset();
        cmd(dbf_pkg::OP_RESET, 1'b1, 1'b0, 18'h00000, 8'h00);
        chk(u_flash.rst_cnt, 1);
    endtask : t_reset
    // Strobe write on bank 0, then raw read of bank 1 while bank 0 is busy.
    task automatic t_we_write_concurrent();
        cmd(dbf_pkg::OP_WRITE, 1'b0, 1'b0, 18'h00123, 8'h40);
        chk(u_flash.lat_addr, 32'h00123);
        chk(u_flash.lat_data, 32'h40);
        cmd(dbf_pkg::OP_READ, 1'b1, 1'b0, 18'h00010, 8'h00);
        chk(o_rdata, 32'h85);
        cmd(dbf_pkg::OP_READ, 1'b0, 1'b0, 18'h00010, 8'h00);
        chk(o_rdata, 32'h05);
    endtask : t_we_write_concurrent
    // Select write at the top address, then poll that bank to ready.
    task automatic t_sel_write_poll();
        t0 = $realtime;
        cmd(dbf_pkg::OP_WRITE, 1'b1, 1'b1, 18'h3FFFF, 8'hD0);
        chk(u_flash.lat_addr, 32'h3FFFF);
        chk(u_flash.lat_data, 32'hD0);
        cmd(dbf_pkg::OP_POLL, 1'b1, 1'b0, 18'h00000, 8'h00);
        chk(o_rdata, 32'h80);
        chk(o_ready_seen, 1);
        chk(o_timeout, 0);
        chk($realtime - t0 >= 8000.0, 1);
    endtask : t_sel_write_poll
    // A write that never finishes must end the poll by timeout.
    task automatic t_poll_timeout();
        stall <= 1'b1;
        cmd(dbf_pkg::OP_WRITE, 1'b0, 1'b0, 18'h00001, 8'h20);
        stall <= 1'b0;
        cmd(dbf_pkg::OP_POLL, 1'b0, 1'b0, 18'h00000, 8'h00);
        chk(o_timeout, 1);
        chk(o_ready_seen, 0);
        chk(o_rdata, 32'h00);
    endtask : t_poll_timeout
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // Cuts a hang short.
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // Main sequence.
    initial begin
        {i_nrst, i_cmd_valid, i_cmd_op, i_cmd_bank, i_cmd_sel_ctl, stall} = '0;
        i_cmd_addr = '0;
        i_cmd_data = '0;
        repeat (20) @(posedge i_mclk);
        i_nrst <= 1'b1;
        t_reset();
        t_we_write_concurrent();
        t_sel_write_poll();
        t_poll_timeout();
        print_verdict();
    end
endmodule : tb_dual_bank_flash_bus_control
bind dbf_host_seq dbf_host_seq_checker #(.ADDR_W(ADDR_W)) u_chk (.i_mclk(i_mclk),
    .i_nrst(i_nrst), .o_bank0_select_n(o_bank0_select_n), .o_bank1_select_n(o_bank1_select_n),
    .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr), .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe), .o_timeout(o_timeout));
